/* File: inc/crs_pkg.sv */
/*
  Package for the channel reset, enable and phase-sync control block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 32-bit AXI4-Lite register bus and a single 10 MHz clock.
*/
package crs_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENBEH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FMASK = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PINS = 8'h20;
  // Fields
  localparam int DELAY_W = 5;
  localparam int PERIOD_W = 16;
  localparam int ST_SYNC = 0;
  localparam int ST_ENLOW = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_W = 3;
  // Reset values
  localparam logic [NUM_CH-1:0] ENBEH_RST = 4'h0;
  localparam logic [NUM_CH-1:0] CH_EN_RST = 4'h0;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h03e7;
  localparam logic [ST_W-1:0] IMASK_RST = 3'h0;
  localparam logic [NUM_CH-1:0] FMASK_RST = 4'h0;
  // Timing: 10 MHz clock, PWM tick every 1 us
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_TICK_NS = 1000;
  localparam int PWM_TICK_CYC = (PWM_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : crs_pkg

/* File: src/crs_ctrl.sv */
/*
  Global control of a four-channel current controller: reset, enable
  behaviour, phase-sync restart with per-channel delay, sync event latch,
  open-drain fault output, AXI4-Lite register slave and interrupt.
  Assumes pins are asynchronous and all timing comes from i_mclk.
*/
`timescale 1ns/10ps
module crs_ctrl
  import crs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_reset_n_pin,
  input wire logic i_analog_supply_ok,
  input wire logic i_digital_supply_ok,
  input wire logic i_enable_pin,
  input wire logic i_phase_sync_pin,
  input wire logic [NUM_CH-1:0] i_fault_det,
  input wire logic [NUM_CH-1:0] i_ch_out,
  output logic [NUM_CH-1:0] o_ch_out,
  output logic [NUM_CH-1:0] o_pwm_start,
  output logic o_fault_oe,
  output logic o_fault_out,
  output logic o_irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [4:0] pins_s;
  logic rst_n_s, ana_ok_s, dig_ok_s, en_s, sync_s;
  logic sync_prev;
  logic sync_rise;
  logic soft_rst;
  logic [NUM_CH-1:0] fault_s;

  // Pin levels and fault inputs are asynchronous
  crs_sync #(.W(5), .RST_VAL(5'h00)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async({i_reset_n_pin, i_analog_supply_ok, i_digital_supply_ok, i_enable_pin, i_phase_sync_pin}),
    .o_sync(pins_s)
  );
  crs_sync #(.W(NUM_CH), .RST_VAL(4'h0)) u_fault_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_fault_det),
    .o_sync(fault_s)
  );
  assign {rst_n_s, ana_ok_s, dig_ok_s, en_s, sync_s} = pins_s;

  // Any low supply or pin reset forces defaults
  assign soft_rst = i_reset | ~rst_n_s | ~ana_ok_s | ~dig_ok_s;
  assign sync_rise = sync_s & ~sync_prev;

  // Software-visible state
  logic [NUM_CH-1:0] ch_en, enbeh, fmask, held;
  logic [NUM_CH*DELAY_W-1:0] delays;
  logic [PERIOD_W-1:0] period;
  logic [ST_W-1:0] status, imask;
  logic [NUM_CH-1:0] next_ch_en, next_enbeh, next_fmask, next_held;
  logic [NUM_CH*DELAY_W-1:0] next_delays;
  logic [PERIOD_W-1:0] next_period;
  logic [ST_W-1:0] next_status, next_imask;
  logic next_sync_prev;

  // AXI handshake state
  logic aw_got, w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_got, next_w_got, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic next_awready, next_wready, next_arready;
  logic do_wr, do_rd;

  logic [NUM_CH-1:0] next_ch_out, next_pwm_start, pwm_raw;
  logic next_fault_oe, next_irq;
  logic tick, next_tick;
  logic [15:0] tick_cnt, next_tick_cnt;

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a == OFS_CTRL) || (a == OFS_ENBEH) || (a == OFS_DELAY) || (a == OFS_PERIOD) ||
                 (a == OFS_STATUS) || (a == OFS_IMASK) || (a == OFS_FAULT) || (a == OFS_FMASK) ||
                 (a == OFS_PINS);
  endfunction : known_addr

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      wmerge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
  endfunction : wmerge

  // Timebase divider from the master clock
  always_comb
  begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 16'h0001;
    if (soft_rst || tick_cnt == 16'(PWM_TICK_CYC - 1))
    begin
      next_tick_cnt = 16'h0000;
      next_tick = ~soft_rst;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      crs_pwm_ch u_ch (
        .i_mclk(i_mclk),
        .i_reset(soft_rst),
        .i_tick(tick),
        .i_restart(sync_rise),
        .i_period(period),
        .i_phase_delay_value(delays[g*DELAY_W +: DELAY_W]),
        .o_pwm_start(pwm_raw[g])
      );
    end
  endgenerate

  // Bus handshake: write address and data taken in either order
  assign do_wr = aw_got && w_got && !s_axi_bvalid;
  assign do_rd = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_wr)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = known_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (do_rd)
    begin
      next_rvalid = 1'b1;
      next_rresp = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL: next_rdata = 32'(ch_en);
        OFS_ENBEH: next_rdata = 32'(enbeh);
        OFS_DELAY: next_rdata = 32'(delays);
        OFS_PERIOD: next_rdata = 32'(period);
        OFS_STATUS: next_rdata = 32'(status);
        OFS_IMASK: next_rdata = 32'(imask);
        OFS_FAULT: next_rdata = 32'(fault_s);
        OFS_FMASK: next_rdata = 32'(fmask);
        OFS_PINS: next_rdata = 32'({en_s, sync_s});
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
    if (i_reset)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b0;
      next_rvalid = 1'b0;
      next_awready = 1'b0;
      next_wready = 1'b0;
      next_arready = 1'b0;
    end
  end

  // Registers, sticky events and channel gating
  always_comb
  begin
    next_ch_en = ch_en;
    next_enbeh = enbeh;
    next_fmask = fmask;
    next_delays = delays;
    next_period = period;
    next_imask = imask;
    next_status = status;
    next_sync_prev = sync_s;
    if (do_wr)
    begin
      case (aw_addr)
        OFS_CTRL: next_ch_en = NUM_CH'(wmerge(32'(ch_en), w_data, w_strb));
        OFS_ENBEH: next_enbeh = NUM_CH'(wmerge(32'(enbeh), w_data, w_strb));
        OFS_DELAY: next_delays = (NUM_CH*DELAY_W)'(wmerge(32'(delays), w_data, w_strb));
        OFS_PERIOD: next_period = PERIOD_W'(wmerge(32'(period), w_data, w_strb));
        OFS_IMASK: next_imask = ST_W'(wmerge(32'(imask), w_data, w_strb));
        OFS_FMASK: next_fmask = NUM_CH'(wmerge(32'(fmask), w_data, w_strb));
        default: next_ch_en = ch_en;
      endcase
    end
    // Read clears, but a same-cycle event wins
    if (do_rd && s_axi_araddr == OFS_STATUS)
      next_status = '0;
    if (sync_rise)
      next_status[ST_SYNC] = 1'b1;
    if (!en_s)
      next_status[ST_ENLOW] = 1'b1;
    if (|(fault_s & ~fmask))
      next_status[ST_FAULT] = 1'b1;
    if (soft_rst)
    begin
      next_ch_en = CH_EN_RST;
      next_enbeh = ENBEH_RST;
      next_fmask = FMASK_RST;
      next_delays = '0;
      next_period = PERIOD_RST;
      next_imask = IMASK_RST;
      next_status = '0;
      next_sync_prev = 1'b0;
    end
  end

  always_comb
  begin
    // Hold mode freezes the last driven level while enable is low
    next_held = en_s ? (i_ch_out & ch_en) : held;
    for (int c = 0; c < NUM_CH; c++)
      next_ch_out[c] = en_s ? (i_ch_out[c] & ch_en[c]) : (enbeh[c] & held[c]);
    next_pwm_start = pwm_raw;
    next_fault_oe = |(fault_s & ~fmask);
    next_irq = |(next_status & imask);
    if (soft_rst)
    begin
      next_held = '0;
      next_ch_out = '0;
      next_pwm_start = '0;
      next_fault_oe = 1'b0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    tick_cnt <= next_tick_cnt;
    tick <= next_tick;
    sync_prev <= next_sync_prev;
    ch_en <= next_ch_en;
    enbeh <= next_enbeh;
    fmask <= next_fmask;
    delays <= next_delays;
    period <= next_period;
    imask <= next_imask;
    status <= next_status;
    held <= next_held;
    aw_got <= next_aw_got;
    w_got <= next_w_got;
    aw_addr <= next_aw_addr;
    w_data <= next_w_data;
    w_strb <= next_w_strb;
    s_axi_awready <= next_awready;
    s_axi_wready <= next_wready;
    s_axi_arready <= next_arready;
    s_axi_bvalid <= next_bvalid;
    s_axi_bresp <= next_bresp;
    s_axi_rvalid <= next_rvalid;
    s_axi_rdata <= next_rdata;
    s_axi_rresp <= next_rresp;
    o_ch_out <= next_ch_out;
    o_pwm_start <= next_pwm_start;
    o_fault_oe <= next_fault_oe;
    o_fault_out <= 1'b0;
    o_irq <= next_irq;
  end
endmodule : crs_ctrl

/* File: src/crs_pwm_ch.sv */
/*
  One channel's PWM period counter with phase-sync delayed start.
  Assumes i_tick is a one-cycle enable from the shared divider, same clock.
*/
`timescale 1ns/10ps
module crs_pwm_ch
  import crs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic i_restart,
  input wire logic [PERIOD_W-1:0] i_period,
  input wire logic [DELAY_W-1:0] i_phase_delay_value,
  output logic o_pwm_start
);
  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] dly;
  logic waiting;
  logic [PERIOD_W-1:0] next_cnt;
  logic [PERIOD_W-1:0] next_dly;
  logic next_waiting;
  logic next_start;
  logic [PERIOD_W+DELAY_W-1:0] prod;

  always_comb
  begin
    // Delay in 1/32 steps of the period
    // The period register holds ticks minus one, so the full period is one more
    prod = ((PERIOD_W+DELAY_W)'(i_period) + (PERIOD_W+DELAY_W)'(1)) * (PERIOD_W+DELAY_W)'(i_phase_delay_value);
    next_cnt = cnt;
    next_dly = dly;
    next_waiting = waiting;
    next_start = 1'b0;
    if (i_reset)
    begin
      next_cnt = '0;
      next_dly = '0;
      next_waiting = 1'b0;
    end
    else if (i_restart)
    begin
      next_cnt = '0;
      next_dly = prod[PERIOD_W+DELAY_W-1:DELAY_W];
      next_waiting = 1'b1;
    end
    else if (i_tick)
    begin
      if (waiting)
      begin
        if (dly == '0)
        begin
          next_waiting = 1'b0;
          next_start = 1'b1;
        end
        else
          next_dly = dly - 1'b1;
      end
      else if (cnt >= i_period)
      begin
        next_cnt = '0;
        next_start = 1'b1;
      end
      else
        next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    cnt <= next_cnt;
    dly <= next_dly;
    waiting <= next_waiting;
    o_pwm_start <= next_start;
  end
endmodule : crs_pwm_ch

/* File: src/crs_sync.sv */
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes i_reset is synchronous to i_mclk; output only from the second stage.
*/
`timescale 1ns/10ps
module crs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb
  begin
    next_stage1 = i_reset ? RST_VAL : i_async;
    next_sync = i_reset ? RST_VAL : stage1;
  end

  always_ff @(posedge i_mclk)
  begin
    stage1 <= next_stage1;
    o_sync <= next_sync;
  end
endmodule : crs_sync

/* File: tb/crs_ctrl_props.sv */
/*
  Port checker for crs_ctrl, bound to every instance.
  Assumes one clock i_mclk and synchronous reset i_reset.
*/
`timescale 1ns/10ps
module crs_ctrl_props
  import crs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_reset_n_pin,
  input wire logic i_analog_supply_ok,
  input wire logic i_digital_supply_ok,
  input wire logic i_enable_pin,
  input wire logic [NUM_CH-1:0] i_fault_det,
  input wire logic [NUM_CH-1:0] o_ch_out,
  input wire logic [NUM_CH-1:0] o_pwm_start,
  input wire logic o_fault_oe,
  input wire logic o_fault_out,
  input wire logic o_irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic pwr_ok;
  assign pwr_ok = i_analog_supply_ok && i_digital_supply_ok && i_reset_n_pin;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // Six cycles cover the pin synchroniser and the output register
  a_pin_reset_off: assert property ((!i_reset_n_pin) [*6] |-> o_ch_out == 4'h0 && !o_irq)
    else $error("Outputs active while reset pin low");
  a_supply_low_off: assert property ((!(i_analog_supply_ok && i_digital_supply_ok)) [*6] |-> o_ch_out == 4'h0)
    else $error("Outputs active while supply low");
  a_enable_low_frozen: assert property ((!i_enable_pin && pwr_ok) [*6] |-> $stable(o_ch_out))
    else $error("Channel outputs move while enable low");
  a_fault_pin_quiet: assert property ((i_fault_det == 4'h0) [*6] |-> !o_fault_oe)
    else $error("Fault pin pulled without fault");
  a_fault_open_drain: assert property (o_fault_oe |-> !o_fault_out)
    else $error("Fault pin driven high");
  a_pwm_one_cycle: assert property ((|o_pwm_start) |=> (o_pwm_start & $past(o_pwm_start)) == 4'h0)
    else $error("Period start longer than one cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer late");
  a_read_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read accepted while answer pending");
  cover property ((!i_enable_pin) [*6]);
  cover property (o_pwm_start[3]);
  cover property (o_irq);
  cover property (o_fault_oe);
endmodule : crs_ctrl_props

bind crs_ctrl crs_ctrl_props crs_ctrl_props_inst (.i_mclk, .i_reset, .i_reset_n_pin, .i_analog_supply_ok,
  .i_digital_supply_ok, .i_enable_pin, .i_fault_det, .o_ch_out, .o_pwm_start, .o_fault_oe, .o_fault_out,
  .o_irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

/* File: tb/crs_host_pins.sv */
/*
  Host-side pin model: supplies, reset pin and the pulled-up fault wire.
  Assumes bench commands change just after rising edges of i_mclk.
*/
`timescale 1ns/10ps
module crs_host_pins #(
  parameter int SETTLE = 3
) (
  input wire logic i_mclk,
  input wire logic i_supply_on,
  input wire logic i_hold_reset,
  input wire logic i_fault_oe,
  output logic o_analog_supply_ok,
  output logic o_digital_supply_ok,
  output logic o_reset_n_pin,
  output logic o_fault_pin_n
);
  int settle_cnt = 0;
  // Pull-up restores the wire when released
  assign o_fault_pin_n = i_fault_oe ? 1'h0 : 1'h1;
  initial
  begin
    o_analog_supply_ok = 1'h0;
    o_digital_supply_ok = 1'h0;
    o_reset_n_pin = 1'h0;
  end
  always @(posedge i_mclk)
  begin
    settle_cnt <= !i_supply_on ? 0 : (settle_cnt < SETTLE ? settle_cnt + 1 : settle_cnt);
    // Odd delays keep the pins out of phase with the clock
    o_analog_supply_ok <= #23 i_supply_on;
    o_digital_supply_ok <= #31 i_supply_on;
    o_reset_n_pin <= #41 (settle_cnt >= SETTLE) && !i_hold_reset;
  end
endmodule : crs_host_pins

/* File: tb/tb.sv */
/*
  Self-checking bench for crs_ctrl with the host pin model.
  Assumes the register map and latencies of the designer's note.
*/
`timescale 1ns/10ps
module tb
  import crs_pkg::*;
;
  logic i_mclk = 1'h0;
  logic i_reset = 1'h1;
  logic i_enable_pin = 1'h1;
  logic i_phase_sync_pin = 1'h0;
  logic [NUM_CH-1:0] i_fault_det = 4'h0;
  logic [NUM_CH-1:0] i_ch_out = 4'h0;
  logic sup_on = 1'h1;
  logic hold_rst = 1'h0;
  logic i_reset_n_pin, i_analog_supply_ok, i_digital_supply_ok, fault_pin_n;
  logic [NUM_CH-1:0] o_ch_out, o_pwm_start;
  logic o_fault_oe, o_fault_out, o_irq;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_st[NUM_CH];
  int lat0;
  logic [31:0] seed = 32'h1e8a;
  logic [31:0] r;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  localparam logic [7:0] RST_ADR[7] = '{OFS_CTRL, OFS_ENBEH, OFS_DELAY, OFS_PERIOD, OFS_STATUS, OFS_IMASK, OFS_FMASK};
  localparam logic [31:0] RST_VAL[7] = '{32'h0, 32'h0, 32'h0, 32'h3e7, 32'h0, 32'h0, 32'h0};
  localparam int DLY[NUM_CH] = '{0, 1, 16, 31};

  crs_ctrl crs_ctrl_inst (.i_mclk, .i_reset, .i_reset_n_pin, .i_analog_supply_ok, .i_digital_supply_ok,
    .i_enable_pin, .i_phase_sync_pin, .i_fault_det, .i_ch_out, .o_ch_out, .o_pwm_start, .o_fault_oe, .o_fault_out,
    .o_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  crs_host_pins crs_host_pins_inst (.i_mclk, .i_supply_on(sup_on), .i_hold_reset(hold_rst), .i_fault_oe(o_fault_oe),
    .o_analog_supply_ok(i_analog_supply_ok), .o_digital_supply_ok(i_digital_supply_ok),
    .o_reset_n_pin(i_reset_n_pin), .o_fault_pin_n(fault_pin_n));

  always #50 i_mclk = ~i_mclk;

  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
    chk_val("read data", e[31:0], g[31:0]);
    chk_val("read resp", {30'h0, e[33:32]}, {30'h0, g[33:32]});
  endtask : chk_rd

  task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
    chk_val("write resp", {30'h0, e}, {30'h0, g});
  endtask : chk_b

  // Ceiling well above the fewer than two thousand cycles the sequence needs
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  always @(posedge i_mclk)
  begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
      chk_rd(exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
      chk_b(exp_b.pop_front(), s_axi_bresp);
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc_wait

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    exp_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge i_mclk);
      aw_ok = aw_ok || s_axi_awready === 1'h1;
      w_ok = w_ok || s_axi_wready === 1'h1;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge i_mclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    // One idle edge so the next call never re-raises bready in this step
    @(posedge i_mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    exp_r.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge i_mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge i_mclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge i_mclk);
  endtask : rd

  // Single sync edge, then note each channel's first period start
  task automatic pwm_run();
    t_st = '{-1, -1, -1, -1};
    i_phase_sync_pin <= 1'h1;
    for (int k = 0; k < 400; k++)
    begin
      @(posedge i_mclk);
      if (k == 4)
        i_phase_sync_pin <= 1'h0;
      for (int c = 0; c < NUM_CH; c++)
        if (o_pwm_start[c] === 1'h1 && t_st[c] < 0)
          t_st[c] = k;
    end
  endtask : pwm_run

  initial
  begin
    cyc_wait(2);
    i_reset <= 1'h0;
    cyc_wait(15);
    for (int k = 0; k < 7; k++)
      rd(RST_ADR[k], RST_VAL[k], RESP_OKAY);
    rd(OFS_PINS, 32'h2, RESP_OKAY);
    wr(8'h40, rnd(), RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    r = rnd();
    wr(OFS_DELAY, r, RESP_OKAY);
    rd(OFS_DELAY, r & 32'hfffff, RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wr(OFS_DELAY, 32'h0, RESP_OKAY);
    rd(OFS_DELAY, r & 32'hf00ff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    r = rnd() | 32'h1;
    wr(OFS_CTRL, 32'hf, RESP_OKAY);
    i_ch_out <= r[3:0];
    cyc_wait(8);
    chk_val("ch_out", {28'h0, r[3:0]}, {28'h0, o_ch_out});
    i_enable_pin <= 1'h0;
    cyc_wait(8);
    chk_val("ch_out", 32'h0, {28'h0, o_ch_out});
    i_enable_pin <= 1'h1;
    wr(OFS_ENBEH, 32'h5, RESP_OKAY);
    i_ch_out <= 4'hf;
    cyc_wait(8);
    i_enable_pin <= 1'h0;
    cyc_wait(8);
    i_ch_out <= 4'h0;
    cyc_wait(8);
    chk_val("ch_out", 32'h5, {28'h0, o_ch_out});
    i_enable_pin <= 1'h1;
    cyc_wait(8);
    chk_val("ch_out", 32'h0, {28'h0, o_ch_out});
    chk_val("irq", 32'h0, {31'h0, o_irq});
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    i_fault_det <= 4'h2;
    cyc_wait(8);
    chk_val("fault wire", 32'h0, {31'h0, fault_pin_n});
    rd(OFS_FAULT, 32'h2, RESP_OKAY);
    wr(OFS_FMASK, 32'h2, RESP_OKAY);
    cyc_wait(6);
    chk_val("fault wire", 32'h1, {31'h0, fault_pin_n});
    i_fault_det <= 4'h0;
    wr(OFS_FMASK, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h4, RESP_OKAY);
    wr(OFS_PERIOD, 32'h1f, RESP_OKAY);
    wr(OFS_DELAY, 32'hfc020, RESP_OKAY);
    wr(OFS_IMASK, 32'h1, RESP_OKAY);
    // First run only aligns the free-running periods
    pwm_run();
    pwm_run();
    lat0 = t_st[0];
    for (int c = 1; c < NUM_CH; c++)
      chk_val("start offset", 32'(10 * DLY[c]), 32'(t_st[c] - lat0));
    // Whole tick periods keep the divider phase equal between runs
    cyc_wait(140);
    pwm_run();
    chk_val("restart lag", 32'(lat0), 32'(t_st[0]));
    chk_val("irq", 32'h1, {31'h0, o_irq});
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    cyc_wait(4);
    chk_val("irq", 32'h0, {31'h0, o_irq});
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    i_ch_out <= 4'hf;
    hold_rst <= 1'h1;
    cyc_wait(8);
    chk_val("ch_out", 32'h0, {28'h0, o_ch_out});
    hold_rst <= 1'h0;
    cyc_wait(15);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_ENBEH, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'hf, RESP_OKAY);
    cyc_wait(4);
    chk_val("ch_out", 32'hf, {28'h0, o_ch_out});
    sup_on <= 1'h0;
    cyc_wait(8);
    chk_val("ch_out", 32'h0, {28'h0, o_ch_out});
    sup_on <= 1'h1;
    cyc_wait(20);
    rd(OFS_PERIOD, 32'h3e7, RESP_OKAY);
    rd(OFS_DELAY, 32'h0, RESP_OKAY);
    print_verdict();
  end
endmodule : tb
